// ==== src/framer_pkg.sv ====
// constants, types and code tables shared by the serial link word framer
package framer_pkg;

	// ********************************************************
	// register map and fields
	// ********************************************************
	localparam logic [7:0] REG_LINK_CTRL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h06;
	localparam logic [7:0] REG_AUX = 8'h07;
	localparam logic [7:0] REG_TRIG_CTRL = 8'h15;
	localparam logic [7:0] LINK_CTRL_RST = 8'h02;
	localparam logic [7:0] LINK_CTRL_MASK = 8'h03;
	localparam logic [7:0] TRIG_CTRL_RST = 8'h01;
	localparam logic [7:0] TRIG_CTRL_MASK = 8'h07;
	localparam int LC_RATE_BIT = 0;
	localparam int LC_AUDIO_BIT = 1;
	localparam int TC_DETRIG_BIT = 0;
	localparam int TC_SEL_LSB = 1;
	localparam int ST_OVERRUN_BIT = 2;

	// ********************************************************
	// serial word layout
	// ********************************************************
	localparam int VID24_BITS = 21;
	localparam int VID32_BITS = 29;
	localparam int VIDHB_BITS = 24;
	localparam int HS_POS = 18;
	localparam int VS_POS = 19;
	localparam int DE_POS = 20;
	localparam logic [7:0] PKT_MARKER = 8'hF0;
	localparam logic [5:0] CODED_SHORT = 6'h1E;
	localparam logic [5:0] CODED_LONG = 6'h28;
	localparam logic [15:0] LFSR_SEED = 16'hFFFF;

	// ********************************************************
	// modes and states
	// ********************************************************
	typedef enum logic [1:0] {
		MODE_24 = 2'h0,
		MODE_HB = 2'h1,
		MODE_32 = 2'h3
	} width_mode_e;

	typedef enum logic [1:0] {
		AUD_IDLE = 2'h0,
		AUD_START = 2'h1,
		AUD_WS = 2'h3,
		AUD_SD = 2'h2
	} aud_state_e;

	localparam logic [1:0] TRIG_DEFAULT = 2'h0;
	localparam logic [1:0] TRIG_ALWAYS = 2'h1;
	localparam logic [1:0] TRIG_SYNC = 2'h2;
	localparam logic [1:0] TRIG_HOLD = 2'h3;

	typedef struct packed {
		logic data_rate_select;
		logic audio_enable;
		logic pixel_valid_trigger_disable;
		logic [1:0] control_trigger_select;
	} cfg_s;

	typedef struct packed {
		logic line_sync;
		logic frame_sync;
		logic pixel_valid;
	} sync_s;

	// ********************************************************
	// line code tables, negative running disparity form
	// ********************************************************
	localparam logic [5:0] TBL_5B6B [0:31] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] TBL_3B4B [0:7] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] ALT_7_NEG = 4'h7;

endpackage

// ==== src/serial_link_word_framer.sv ====
// forward-path word framer: packs pixels, sync and audio, aux only in high-bandwidth packets, then codes
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module serial_link_word_framer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// parallel video, pixel clock domain
	input wire logic [28:0] pixel_data,
	input wire logic [3:0] aux_control_lines,
	// asynchronous pins
	input wire logic [1:0] bus_width_select,
	input wire logic audio_bit_clock,
	input wire logic audio_word_select,
	input wire logic audio_serial_data,
	input wire logic fwd_ctrl_bit,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// link side
	output logic [31:0] serial_word,
	output logic [39:0] link_word,
	output logic [5:0] link_word_bits,
	output logic data_rate_select
);

	// ********************************************************
	// code functions
	// ********************************************************
	function automatic logic [10:0] enc_8b10b(input logic [7:0] d,
		input logic rd);
		logic [5:0] six;
		logic [3:0] four;
		logic rd1;
		logic alt;
		six = framer_pkg::TBL_5B6B[d[4:0]];
		rd1 = rd;
		if ($countones(six) != 3)
		begin
			if (rd)
				six = ~six;
			rd1 = ~rd;
		end
		else if (d[4:0] == 5'h07 && rd)
			six = ~six;
		four = framer_pkg::TBL_3B4B[d[7:5]];
		alt = (d[7:5] == 3'h7) && ((!rd1 && (d[4:0] == 5'h11 ||
			d[4:0] == 5'h12 || d[4:0] == 5'h14)) || (rd1 &&
			(d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
		if (alt)
			four = framer_pkg::ALT_7_NEG;
		if ($countones(four) != 2)
		begin
			if (rd1)
				four = ~four;
			enc_8b10b = {~rd1, six, four};
		end
		else
		begin
			if (rd1 && d[7:5] == 3'h3)
				four = ~four;
			enc_8b10b = {rd1, six, four};
		end
	endfunction

	// bus-invert code: flag bit on top, inversion pulls disparity back
	function automatic logic [10:0] enc_9b10b(input logic [8:0] d,
		input logic rd);
		logic inv;
		logic [9:0] sym;
		int ones;
		inv = rd ? ($countones(d) > 4) : ($countones(d) < 5);
		sym = {inv, d ^ {9{inv}}};
		ones = $countones(sym);
		if (ones > 5)
			enc_9b10b = {1'b1, sym};
		else if (ones < 5)
			enc_9b10b = {1'b0, sym};
		else
			enc_9b10b = {rd, sym};
	endfunction

	function automatic logic [47:0] scramble(input logic [15:0] lfsr);
		logic [15:0] s;
		logic [31:0] ks;
		s = lfsr;
		ks = 32'h0000_0000;
		for (int i = 0; i < 32; i++)
		begin
			ks[i] = s[15];
			s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		end
		scramble = {s, ks};
	endfunction

	// ********************************************************
	// pin synchronisers and width strap
	// ********************************************************
	logic [5:0] meta_reg;
	logic [5:0] sync_reg;
	logic sck_sync;
	logic ws_sync;
	logic sd_sync;
	logic fwd_sync;
	framer_pkg::width_mode_e mode_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= 6'h00;
			sync_reg <= 6'h00;
		end
		else
		begin
			meta_reg <= {bus_width_select, audio_bit_clock,
				audio_word_select, audio_serial_data, fwd_ctrl_bit};
			sync_reg <= meta_reg;
		end
	end

	assign sck_sync = sync_reg[3];
	assign ws_sync = sync_reg[2];
	assign sd_sync = sync_reg[1];
	assign fwd_sync = sync_reg[0];

	// the open level selects high-bandwidth; the illegal code falls to 24
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			mode_reg <= framer_pkg::MODE_24;
		else
		begin
			case (sync_reg[5:4])
				2'h1: mode_reg <= framer_pkg::MODE_HB;
				2'h3: mode_reg <= framer_pkg::MODE_32;
				default: mode_reg <= framer_pkg::MODE_24;
			endcase
		end
	end

	// ********************************************************
	// register port
	// ********************************************************
	logic [7:0] link_ctrl_reg;
	logic [7:0] trig_ctrl_reg;
	logic [7:0] rdata_reg;
	logic overrun_reg;
	logic [4:0] aux_held_reg;
	framer_pkg::cfg_s cfg;

	assign cfg.data_rate_select = link_ctrl_reg[framer_pkg::LC_RATE_BIT];
	assign cfg.audio_enable = link_ctrl_reg[framer_pkg::LC_AUDIO_BIT];
	assign cfg.pixel_valid_trigger_disable =
		trig_ctrl_reg[framer_pkg::TC_DETRIG_BIT];
	assign cfg.control_trigger_select =
		trig_ctrl_reg[framer_pkg::TC_SEL_LSB +: 2];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			link_ctrl_reg <= framer_pkg::LINK_CTRL_RST;
			trig_ctrl_reg <= framer_pkg::TRIG_CTRL_RST;
		end
		else if (reg_write)
		begin
			if (reg_addr == framer_pkg::REG_LINK_CTRL)
				link_ctrl_reg <= reg_wdata & framer_pkg::LINK_CTRL_MASK;
			if (reg_addr == framer_pkg::REG_TRIG_CTRL)
				trig_ctrl_reg <= reg_wdata & framer_pkg::TRIG_CTRL_MASK;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (!reg_read)
			rdata_reg <= 8'h00;
		else
		begin
			case (reg_addr)
				framer_pkg::REG_LINK_CTRL: rdata_reg <= link_ctrl_reg;
				framer_pkg::REG_TRIG_CTRL: rdata_reg <= trig_ctrl_reg;
				framer_pkg::REG_STATUS: rdata_reg <= {5'h00, overrun_reg,
					mode_reg};
				framer_pkg::REG_AUX: rdata_reg <= {3'h0, aux_held_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// ********************************************************
	// audio re-encoding
	// ********************************************************
	// each bit clock rise becomes three word slots: start, ws, sd;
	// the stream follows the bit clock only, so any spread applied to the
	// serial output cannot alter the audio rate
	logic sck_prev_reg;
	logic aud_pend_reg;
	logic aud_pend_ws_reg;
	logic aud_pend_sd_reg;
	logic aud_ws_reg;
	logic aud_sd_reg;
	framer_pkg::aud_state_e aud_state_reg;
	logic sck_rise;
	logic aud_take;
	logic aud_bit;

	assign sck_rise = sck_sync & ~sck_prev_reg & cfg.audio_enable;
	assign aud_take = aud_pend_reg && (aud_state_reg == framer_pkg::AUD_IDLE
		|| aud_state_reg == framer_pkg::AUD_SD);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_prev_reg <= 1'b0;
			aud_pend_reg <= 1'b0;
			aud_pend_ws_reg <= 1'b0;
			aud_pend_sd_reg <= 1'b0;
		end
		else
		begin
			sck_prev_reg <= sck_sync;
			if (sck_rise)
			begin
				aud_pend_reg <= 1'b1;
				aud_pend_ws_reg <= ws_sync;
				aud_pend_sd_reg <= sd_sync;
			end
			else if (aud_take || !cfg.audio_enable)
				aud_pend_reg <= 1'b0;
		end
	end

	// a lost bit means the pixel clock is too slow for the audio rate
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			overrun_reg <= 1'b0;
		else if (sck_rise && aud_pend_reg && !aud_take)
			overrun_reg <= 1'b1;
		else if (reg_write && reg_addr == framer_pkg::REG_STATUS &&
			reg_wdata[framer_pkg::ST_OVERRUN_BIT])
			overrun_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			aud_state_reg <= framer_pkg::AUD_IDLE;
			aud_ws_reg <= 1'b0;
			aud_sd_reg <= 1'b0;
		end
		else
		begin
			if (aud_take)
			begin
				aud_ws_reg <= aud_pend_ws_reg;
				aud_sd_reg <= aud_pend_sd_reg;
			end
			case (aud_state_reg)
				framer_pkg::AUD_IDLE:
					if (aud_take)
						aud_state_reg <= framer_pkg::AUD_START;
				framer_pkg::AUD_START: aud_state_reg <= framer_pkg::AUD_WS;
				framer_pkg::AUD_WS: aud_state_reg <= framer_pkg::AUD_SD;
				framer_pkg::AUD_SD:
					aud_state_reg <= aud_take ? framer_pkg::AUD_START :
						framer_pkg::AUD_IDLE;
				default: aud_state_reg <= framer_pkg::AUD_IDLE;
			endcase
		end
	end

	always_comb
	begin
		case (aud_state_reg)
			framer_pkg::AUD_START: aud_bit = 1'b1;
			framer_pkg::AUD_WS: aud_bit = aud_ws_reg;
			framer_pkg::AUD_SD: aud_bit = aud_sd_reg;
			default: aud_bit = 1'b0;
		endcase
	end

	// ********************************************************
	// pixel pipeline, packet triggers and aux sampling
	// ********************************************************
	// one pixel of look-ahead lets a packet go out before a rising edge
	logic [28:0] in_pix_reg;
	logic [28:0] cur_pix_reg;
	logic [3:0] in_aux_reg;
	logic [3:0] cur_aux_reg;
	framer_pkg::sync_s prv_s_reg;
	framer_pkg::sync_s cur_s;
	framer_pkg::sync_s nxt_s;
	logic [2:0] trig_mask;
	logic [2:0] rise_ahead;
	logic [2:0] fall_after;
	logic sync_trans;
	logic aux_en;
	logic [4:0] aux_now;
	logic [4:0] aux_new;
	logic pkt;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			in_pix_reg <= 29'h0000_0000;
			cur_pix_reg <= 29'h0000_0000;
			in_aux_reg <= 4'h0;
			cur_aux_reg <= 4'h0;
			prv_s_reg <= 3'h0;
		end
		else
		begin
			in_pix_reg <= pixel_data;
			cur_pix_reg <= in_pix_reg;
			in_aux_reg <= aux_control_lines;
			cur_aux_reg <= in_aux_reg;
			prv_s_reg <= cur_s;
		end
	end

	assign cur_s = {cur_pix_reg[framer_pkg::HS_POS],
		cur_pix_reg[framer_pkg::VS_POS], cur_pix_reg[framer_pkg::DE_POS]};
	assign nxt_s = {in_pix_reg[framer_pkg::HS_POS],
		in_pix_reg[framer_pkg::VS_POS], in_pix_reg[framer_pkg::DE_POS]};
	assign trig_mask = {2'h3, cfg.pixel_valid_trigger_disable};
	assign rise_ahead = nxt_s & ~cur_s & trig_mask;
	assign fall_after = prv_s_reg & ~cur_s & trig_mask;
	assign sync_trans = (cur_s.line_sync != prv_s_reg.line_sync) ||
		(cur_s.frame_sync != prv_s_reg.frame_sync);
	// with audio off the audio data line rides as a fifth aux line
	assign aux_now = {cfg.audio_enable ? 1'b0 : sd_sync, cur_aux_reg};

	always_comb
	begin
		case (cfg.control_trigger_select)
			framer_pkg::TRIG_DEFAULT:
				aux_en = !cur_s.pixel_valid || sync_trans;
			framer_pkg::TRIG_ALWAYS: aux_en = 1'b1;
			framer_pkg::TRIG_SYNC: aux_en = sync_trans;
			default: aux_en = 1'b0;
		endcase
	end

	assign aux_new = aux_en ? aux_now : aux_held_reg;
	assign pkt = (mode_reg == framer_pkg::MODE_HB) && ((|rise_ahead) ||
		(|fall_after) || (aux_new != aux_held_reg));

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			aux_held_reg <= 5'h00;
		else
			aux_held_reg <= aux_new;
	end

	// ********************************************************
	// serial word assembly
	// ********************************************************
	logic [31:0] word_next;
	logic [31:0] word_reg;
	logic word_pkt_reg;
	framer_pkg::width_mode_e word_mode_reg;
	logic tail_audio;

	assign tail_audio = cfg.audio_enable ? aud_bit : sd_sync;

	always_comb
	begin
		word_next = 32'h0000_0000;
		case (mode_reg)
			framer_pkg::MODE_32:
			begin
				word_next[framer_pkg::VID32_BITS-1:0] = cur_pix_reg;
				word_next[framer_pkg::VID32_BITS] = tail_audio;
				word_next[framer_pkg::VID32_BITS+1] = fwd_sync;
				word_next[framer_pkg::VID32_BITS+2] =
					^word_next[framer_pkg::VID32_BITS+1:0];
			end
			framer_pkg::MODE_HB:
			begin
				if (pkt)
					word_next[framer_pkg::VIDHB_BITS-1:0] = {
						framer_pkg::PKT_MARKER, 2'h0, aux_new, cur_s, nxt_s,
						3'h0};
				else
					word_next[framer_pkg::VIDHB_BITS-1:0] = {
						cur_pix_reg[26:25], cur_pix_reg[17:12],
						cur_pix_reg[24:23], cur_pix_reg[11:6],
						cur_pix_reg[22:21], cur_pix_reg[5:0]};
				word_next[framer_pkg::VIDHB_BITS] = tail_audio;
				word_next[framer_pkg::VIDHB_BITS+1] = fwd_sync;
				word_next[framer_pkg::VIDHB_BITS+2] =
					^word_next[framer_pkg::VIDHB_BITS+1:0];
			end
			default:
			begin
				word_next[framer_pkg::VID24_BITS-1:0] =
					cur_pix_reg[framer_pkg::VID24_BITS-1:0];
				word_next[framer_pkg::VID24_BITS] = tail_audio;
				word_next[framer_pkg::VID24_BITS+1] = fwd_sync;
				word_next[framer_pkg::VID24_BITS+2] =
					^word_next[framer_pkg::VID24_BITS+1:0];
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			word_reg <= 32'h0000_0000;
			word_pkt_reg <= 1'b0;
			word_mode_reg <= framer_pkg::MODE_24;
		end
		else
		begin
			word_reg <= word_next;
			word_pkt_reg <= pkt;
			word_mode_reg <= mode_reg;
		end
	end

	// ********************************************************
	// scrambler and line coder
	// ********************************************************
	logic [15:0] lfsr_reg;
	logic rd_reg;
	logic [39:0] link_reg;
	logic [5:0] link_bits_reg;
	logic [47:0] scr;
	logic [31:0] scr_word;
	logic [39:0] code_v;
	logic rd_v;
	logic [10:0] sym_v;

	assign scr = scramble(lfsr_reg);
	// the upper bits are zero outside the word, scrambling keeps them so
	assign scr_word = word_reg ^ (scr[31:0] &
		((word_mode_reg == framer_pkg::MODE_32) ? 32'hFFFF_FFFF :
		(word_mode_reg == framer_pkg::MODE_HB) ? 32'h07FF_FFFF :
		32'h00FF_FFFF));

	always_comb
	begin
		code_v = 40'h00_0000_0000;
		rd_v = rd_reg;
		sym_v = 11'h000;
		for (int i = 0; i < 4; i++)
		begin
			if (word_mode_reg == framer_pkg::MODE_HB)
			begin
				if (i < 3)
				begin
					sym_v = enc_9b10b(scr_word[9*i +: 9], rd_v);
					code_v[10*i +: 10] = sym_v[9:0];
					rd_v = sym_v[10];
				end
			end
			else if (i < 3 || word_mode_reg == framer_pkg::MODE_32)
			begin
				sym_v = enc_8b10b(scr_word[8*i +: 8], rd_v);
				code_v[10*i +: 10] = sym_v[9:0];
				rd_v = sym_v[10];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lfsr_reg <= framer_pkg::LFSR_SEED;
			rd_reg <= 1'b0;
			link_reg <= 40'h00_0000_0000;
			link_bits_reg <= framer_pkg::CODED_SHORT;
		end
		else
		begin
			lfsr_reg <= scr[47:32];
			rd_reg <= rd_v;
			link_reg <= code_v;
			link_bits_reg <= (word_mode_reg == framer_pkg::MODE_32) ?
				framer_pkg::CODED_LONG : framer_pkg::CODED_SHORT;
		end
	end

	// rate bit only tells the serializer which clock band to expect
	assign data_rate_select = link_ctrl_reg[framer_pkg::LC_RATE_BIT];
	assign reg_rdata = rdata_reg;
	assign serial_word = word_reg;
	assign link_word = link_reg;
	assign link_word_bits = link_bits_reg;

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_aud_start;
		aud_state_reg == framer_pkg::AUD_START;
	endsequence
	sequence s_aud_rest;
		aud_state_reg == framer_pkg::AUD_WS ##1
			aud_state_reg == framer_pkg::AUD_SD;
	endsequence

	chk_video_low_21: assert property (
		(!$past(rst, 4) && word_mode_reg == framer_pkg::MODE_24) |->
		word_reg[20:0] == $past(pixel_data[20:0], 3))
		else $error("24-bit word video mismatch");
	chk_video_low_29: assert property (
		(!$past(rst, 4) && word_mode_reg == framer_pkg::MODE_32) |->
		word_reg[28:0] == $past(pixel_data, 3))
		else $error("32-bit word video mismatch");
	chk_word_parity: assert property (
		^word_reg == 1'b0)
		else $error("serial word parity odd");
	chk_tail_fwd: assert property (
		word_mode_reg == framer_pkg::MODE_32 |->
		word_reg[30] == $past(fwd_sync))
		else $error("forward control bit misplaced");
	chk_rise_packet: assert property (
		(mode_reg == framer_pkg::MODE_HB && !cur_s.line_sync &&
		nxt_s.line_sync) |=> word_pkt_reg && word_reg[23:16] ==
		framer_pkg::PKT_MARKER)
		else $error("no packet before line sync rise");
	chk_fall_packet: assert property (
		(mode_reg == framer_pkg::MODE_HB && prv_s_reg.frame_sync &&
		!cur_s.frame_sync) |=> word_pkt_reg)
		else $error("no packet after frame sync fall");
	chk_aux_sample: assert property (
		(cfg.control_trigger_select == framer_pkg::TRIG_DEFAULT &&
		!cur_s.pixel_valid) |=> aux_held_reg == $past(aux_now))
		else $error("aux not sampled while valid low");
	chk_aux_hold: assert property (
		(cfg.control_trigger_select == framer_pkg::TRIG_DEFAULT &&
		cur_s.pixel_valid && !sync_trans) |=> $stable(aux_held_reg))
		else $error("aux sampled without sync transition");
	chk_audio_slots: assert property (
		s_aud_start |=> s_aud_rest)
		else $error("audio slot order broken");
	chk_audio_off: assert property (
		(!$past(cfg.audio_enable) && word_mode_reg == framer_pkg::MODE_32)
		|-> word_reg[29] == $past(sd_sync))
		else $error("audio data not passed as aux");
	chk_symbol_balance: assert property (
		link_bits_reg == framer_pkg::CODED_LONG |->
		$countones(link_reg[9:0]) inside {4, 5, 6})
		else $error("8b/10b symbol out of balance");

endmodule
`default_nettype wire

// ==== test/audio_source_model.sv ====
// audio source model: bit clock, word select and serial data
`timescale 1ns/1ps
`default_nettype none
module audio_source_model #(
	parameter int HALF_BITS = 16
) (
	output logic sck = 1'b0,
	output logic ws = 1'b1,
	output logic sd = 1'b0
);
	int n = 0;
	// 80 ns bit clock with its own phase, unrelated to the pixel clock
	initial
	begin
		#3;
		forever #40 sck = ~sck;
	end
	// change on the falling edge so the rising edge samples settled levels
	always @(negedge sck)
	begin
		sd <= 1'($urandom);
		n <= (n + 1) % (2 * HALF_BITS);
		ws <= ((n + 1) % (2 * HALF_BITS)) >= HALF_BITS;
	end
endmodule
`default_nettype wire

// ==== test/serial_link_word_framer_tb.sv ====
// self-checking bench for the serial link word framer
`timescale 1ns/1ps
`default_nettype none
module serial_link_word_framer_tb;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] mask;
	} note_s;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [28:0] pixel_data = '0;
	logic [3:0] aux_control_lines = '0;
	logic [1:0] bus_width_select = 2'h0;
	logic fwd_ctrl_bit = 1'b1;
	logic [7:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic [31:0] serial_word;
	logic [39:0] link_word;
	logic [5:0] link_word_bits;
	logic data_rate_select;
	logic sck;
	logic ws;
	logic sd;
	logic word_go = 1'b0;
	logic [3:0] word_pipe = '0;
	logic reg_pipe = 1'b0;
	note_s word_q[$];
	note_s reg_q[$];
	note_s got;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed_dummy;

	always #5 sys_clk = ~sys_clk;

	audio_source_model i_audio (
		.sck(sck),
		.ws(ws),
		.sd(sd)
	);

	serial_link_word_framer i_dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.pixel_data(pixel_data),
		.aux_control_lines(aux_control_lines),
		.bus_width_select(bus_width_select),
		.audio_bit_clock(sck),
		.audio_word_select(ws),
		.audio_serial_data(sd),
		.fwd_ctrl_bit(fwd_ctrl_bit),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.serial_word(serial_word),
		.link_word(link_word),
		.link_word_bits(link_word_bits),
		.data_rate_select(data_rate_select)
	);

	// ********************************
	// checking
	// ********************************
	task automatic compare(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		word_pipe <= {word_pipe[2:0], word_go};
		reg_pipe <= reg_read;
		cycles <= cycles + 1;
	end

	// words appear three edges after capture, read data one after the read
	always @(negedge sys_clk)
	begin
		if (word_pipe[2] && word_q.size() > 0)
		begin
			got = word_q.pop_front();
			compare("word", got.exp, serial_word & got.mask);
			compare("parity", 32'h0, {31'h0, ^serial_word});
			if (link_word_bits == 6'h28)
				compare("symbol", 32'h1,
					{31'h0, ($countones(link_word[39:30]) inside {4, 5, 6})});
		end
		if (reg_pipe && reg_q.size() > 0)
		begin
			got = reg_q.pop_front();
			compare("rdata", got.exp, {24'h0, reg_rdata});
		end
		if (cycles > 20000)
		begin
			fail_count++;
			stop_test();
		end
	end

	// ********************************
	// stimulus
	// ********************************
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		note_s n;
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		n.exp = {24'h0, e};
		n.mask = 32'hFF;
		reg_q.push_back(n);
		@(posedge sys_clk);
		reg_read <= 1'b0;
	endtask

	task automatic send_words(input int cnt, input logic [31:0] vmask,
		input logic [31:0] mask, input int fpos, input logic hb);
		note_s n;
		logic [28:0] p;
		logic f;
		repeat (cnt)
		begin
			@(posedge sys_clk);
			p = 29'($urandom);
			f = 1'($urandom);
			// sync lines held low so no packet displaces a checked pixel
			if (hb)
				p[20:18] = 3'h0;
			pixel_data <= p;
			fwd_ctrl_bit <= f;
			aux_control_lines <= 4'($urandom);
			word_go <= 1'b1;
			n.mask = mask | (32'h1 << fpos);
			n.exp = ({3'h0, p} & vmask) | (32'(f) << fpos);
			if (hb)
				n.exp = {8'h00, p[26:25], p[17:12], p[24:23], p[11:6],
					p[22:21], p[5:0]} | (32'(f) << fpos);
			word_q.push_back(n);
		end
		@(posedge sys_clk);
		word_go <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask

	initial
	begin
		note_s pk;
		seed_dummy = $urandom(32'h12F84B43);
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		reg_rd(framer_pkg::REG_TRIG_CTRL, 8'h01);
		reg_rd(framer_pkg::REG_LINK_CTRL, 8'h02);
		reg_rd(8'h3F, 8'h00);
		reg_wr(framer_pkg::REG_TRIG_CTRL, 8'hFF);
		reg_rd(framer_pkg::REG_TRIG_CTRL, 8'h07);
		reg_wr(framer_pkg::REG_LINK_CTRL, 8'h01);
		reg_rd(framer_pkg::REG_LINK_CTRL, 8'h01);
		@(posedge sys_clk);
		compare("rate", 32'h1, {31'h0, data_rate_select});
		reg_wr(framer_pkg::REG_TRIG_CTRL, 8'h01);
		reg_wr(framer_pkg::REG_LINK_CTRL, 8'h02);
		$display("test registers done");
		send_words(200, 32'h001F_FFFF, 32'hFF1F_FFFF, 22, 1'b0);
		compare("bits24", 32'h1E, {26'h0, link_word_bits});
		$display("test 24-bit done");
		bus_width_select <= 2'h3;
		reg_wr(framer_pkg::REG_LINK_CTRL, 8'h00);
		repeat (8) @(posedge sys_clk);
		send_words(200, 32'h1FFF_FFFF, 32'h1FFF_FFFF, 30, 1'b0);
		compare("bits32", 32'h28, {26'h0, link_word_bits});
		reg_rd(framer_pkg::REG_STATUS, 8'h03);
		$display("test 32-bit done");
		reg_wr(framer_pkg::REG_LINK_CTRL, 8'h02);
		reg_wr(framer_pkg::REG_TRIG_CTRL, 8'h07);
		bus_width_select <= 2'h1;
		pixel_data <= 29'h000_0000;
		repeat (8) @(posedge sys_clk);
		send_words(200, 32'h0, 32'hF8FF_FFFF, 25, 1'b1);
		// the held pixel ahead of a sync rise goes out as a packet
		pk.exp = 32'h00F0_0030;
		pk.mask = 32'hF8FF_C1FF;
		word_q.push_back(pk);
		word_go <= 1'b1;
		@(posedge sys_clk);
		word_go <= 1'b0;
		pixel_data <= 29'h00C_0000;
		repeat (3) @(posedge sys_clk);
		pixel_data <= 29'h000_0000;
		repeat (8) @(posedge sys_clk);
		reg_rd(framer_pkg::REG_STATUS, 8'h01);
		$display("test high-bandwidth done");
		repeat (10) @(posedge sys_clk);
		stop_test();
	end
endmodule
`default_nettype wire
